// ===== hdl/pirq_regs.sv
// pirq_regs: indirect advanced read port, delay and polarity
// indications, event flags, event mask and the interrupt request.
// assumes a management register engine that issues single-cycle
// read and write strokes with a 5-bit index, and event sources that
// give one-cycle pulses, except energy and link which are levels.
//
// Functional notes
// - read data port, 16 bits read-only, returns captured advanced value, resets 0.
// - address write with read bit and index 0-12 latches data, strobe self-clears.
// - advanced registers cannot be written; reached only by the indirect read.
// - indications bit 9 is read/write transmit clock delay enable.
// - indications bit 8 is read/write receive clock delay enable.
// - delay strap sampled low brings both delay enables up as one.
// - indications bit 4 shows ten meg polarity reversed, read-only, resets 0.
// - flags 10, 9, 8 latch buffer overflow, underflow, idle error overflow.
// - flag 7 latches on a rising edge of energy detected status.
// - flags 6, 3, 1 latch negotiation done, partner ack, page received.
// - flags 5, 4, 2 latch remote fault, link down, detect or role fault.
// - mask bits 10 to 1 enable matching flags, read/write, reset 0.
`timescale 1ns/1ps
module pirq_regs
  import pirq_pkg::*;
(
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 soft_rst_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  input  wire logic [ADDR_W-1:0]    reg_addr_i,
  input  wire logic [DATA_W-1:0]    reg_wdata_i,
  output logic      [DATA_W-1:0]    reg_rdata_o,
  output logic                      reg_rvalid_o,
  input  wire logic                 internal_delay_strap_i,
  input  wire logic                 ten_meg_polarity_reversed_i,
  input  wire logic                 energy_detected_status_i,
  input  wire logic                 link_status_i,
  input  wire logic                 tx_buffer_overflow_i,
  input  wire logic                 tx_buffer_underflow_i,
  input  wire logic                 idle_error_overflow_i,
  input  wire logic                 negotiation_done_i,
  input  wire logic                 remote_fault_i,
  input  wire logic                 partner_ack_i,
  input  wire logic                 parallel_detect_fault_i,
  input  wire logic                 role_fault_i,
  input  wire logic                 page_received_i,
  input  wire logic [DATA_W-1:0]    adv_data_i,
  output logic      [ADV_SEL_W-1:0] adv_sel_o,
  output logic                      adv_rd_o,
  output logic                      tx_delay_en_o,
  output logic                      rx_delay_en_o,
  output logic                      irq_o
);

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    logic              dly_tx;
    logic              dly_rx;
    logic              pol;
    logic [FLAG_W-1:0] mask;
    logic              nrg_prev;
    logic              link_prev;
    logic              irq;
  } pirq_st_t;

  pirq_st_t st_r;
  pirq_st_t st_nxt;

  // decoded write strokes
  logic wr_adv;
  logic wr_ind;
  logic wr_flag;
  logic wr_mask;

  // submodule results
  logic [DATA_W-1:0] adv_port;
  logic [DATA_W-1:0] adv_data;
  logic [FLAG_W-1:0] flags;

  // event collection
  logic [FLAG_W-1:0] ev_set;
  logic [FLAG_W-1:0] ev_clr;
  logic              nrg_rise;
  logic              link_fall;

  // readback images
  logic [DATA_W-1:0] ind_img;
  logic [DATA_W-1:0] flag_img;
  logic [DATA_W-1:0] mask_img;
  logic [DATA_W-1:0] rd_mux;

  // only the address port writes the advanced side; a write to the
  // read data index has no decode and so falls away
  assign wr_adv  = reg_wr_i & (reg_addr_i == ADV_ADDR_OFS);
  assign wr_ind  = reg_wr_i & (reg_addr_i == IND_OFS);
  assign wr_flag = reg_wr_i & (reg_addr_i == FLAG_OFS);
  assign wr_mask = reg_wr_i & (reg_addr_i == MASK_OFS);

  // edges of the level sources
  assign nrg_rise  = energy_detected_status_i & ~st_r.nrg_prev;
  assign link_fall = ~link_status_i & st_r.link_prev;

  always_comb begin
    ev_set = '0;
    ev_set[EV_OVF - FLAG_LO]  = tx_buffer_overflow_i;
    ev_set[EV_UNF - FLAG_LO]  = tx_buffer_underflow_i;
    ev_set[EV_IDLE - FLAG_LO] = idle_error_overflow_i;
    ev_set[EV_NRG - FLAG_LO]  = nrg_rise;
    ev_set[EV_DONE - FLAG_LO] = negotiation_done_i;
    ev_set[EV_ACK - FLAG_LO]  = partner_ack_i;
    ev_set[EV_PAGE - FLAG_LO] = page_received_i;
    ev_set[EV_RFLT - FLAG_LO] = remote_fault_i;
    ev_set[EV_LDN - FLAG_LO]  = link_fall;
    ev_set[EV_DFLT - FLAG_LO] = parallel_detect_fault_i
                              | role_fault_i;
  end

  // writing a one clears that flag; soft reset clears all flags except any set again in that same cycle
  always_comb begin
    ev_clr = '0;
    if (soft_rst_i) begin
      ev_clr = '1;
    end else if (wr_flag) begin
      ev_clr = reg_wdata_i[FLAG_HI:FLAG_LO];
    end
  end

  pirq_flags #(
    .W (FLAG_W)
  ) u_flags (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .set_i      (ev_set),
    .clr_i      (ev_clr),
    .flags_o    (flags)
  );

  pirq_adv_port u_adv (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i | soft_rst_i),
    .wr_i       (wr_adv),
    .wdata_i    (reg_wdata_i),
    .adv_data_i (adv_data_i),
    .port_o     (adv_port),
    .data_o     (adv_data),
    .adv_sel_o  (adv_sel_o),
    .adv_rd_o   (adv_rd_o)
  );

  // readback images, reserved bits read zero
  always_comb begin
    ind_img             = '0;
    ind_img[DLY_TX_BIT] = st_r.dly_tx;
    ind_img[DLY_RX_BIT] = st_r.dly_rx;
    ind_img[POL_BIT]    = st_r.pol;
  end

  always_comb begin
    flag_img                  = '0;
    flag_img[FLAG_HI:FLAG_LO] = flags;
  end

  always_comb begin
    mask_img                  = '0;
    mask_img[FLAG_HI:FLAG_LO] = st_r.mask;
  end

  always_comb begin
    case (reg_addr_i)
      ADV_ADDR_OFS: begin
        rd_mux = adv_port;
      end
      ADV_DATA_OFS: begin
        rd_mux = adv_data;
      end
      IND_OFS: begin
        rd_mux = ind_img;
      end
      FLAG_OFS: begin
        rd_mux = flag_img;
      end
      MASK_OFS: begin
        rd_mux = mask_img;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_comb begin
    st_nxt           = st_r;
    st_nxt.rvalid    = reg_rd_i;
    st_nxt.nrg_prev  = energy_detected_status_i;
    st_nxt.link_prev = link_status_i;
    st_nxt.pol       = ten_meg_polarity_reversed_i;
    if (reg_rd_i) begin
      st_nxt.rdata = rd_mux;
    end
    // delay enables survive a soft reset
    if (wr_ind) begin
      st_nxt.dly_tx = reg_wdata_i[DLY_TX_BIT];
      st_nxt.dly_rx = reg_wdata_i[DLY_RX_BIT];
    end
    if (soft_rst_i) begin
      st_nxt.mask = MASK_RST;
    end else if (wr_mask) begin
      st_nxt.mask = reg_wdata_i[FLAG_HI:FLAG_LO];
    end
    st_nxt.irq = |(flags & st_r.mask);
  end

  // the strap is caught on every edge while reset is held
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r.rdata     <= '0;
      st_r.rvalid    <= 1'b0;
      st_r.dly_tx    <= ~internal_delay_strap_i;
      st_r.dly_rx    <= ~internal_delay_strap_i;
      st_r.pol       <= POL_RST;
      st_r.mask      <= MASK_RST;
      st_r.nrg_prev  <= 1'b0;
      st_r.link_prev <= 1'b0;
      st_r.irq       <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o   = st_r.rdata;
  assign reg_rvalid_o  = st_r.rvalid;
  assign tx_delay_en_o = st_r.dly_tx;
  assign rx_delay_en_o = st_r.dly_rx;
  assign irq_o         = st_r.irq;

endmodule : pirq_regs

// ===== inc/pirq_pkg.sv
// pirq_pkg: offsets, bit positions and reset values of the
// indirect read port, indications, event flag and mask registers.
// assumes a 5-bit management register index and 16-bit data.
package pirq_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 5;

  // register indices on the management register port
  localparam logic [ADDR_W-1:0] ADV_ADDR_OFS = 5'h14;
  localparam logic [ADDR_W-1:0] ADV_DATA_OFS = 5'h15;
  localparam logic [ADDR_W-1:0] IND_OFS      = 5'h1b;
  localparam logic [ADDR_W-1:0] FLAG_OFS     = 5'h1d;
  localparam logic [ADDR_W-1:0] MASK_OFS     = 5'h1e;

  // advanced register address port layout
  localparam int unsigned ADV_RD_BIT   = 15;
  localparam int unsigned ADV_RSV_HI   = 14;
  localparam int unsigned ADV_RSV_LO   = 7;
  localparam int unsigned ADV_IDX_W    = 7;
  localparam int unsigned ADV_SEL_W    = 4;
  localparam logic [ADV_IDX_W-1:0] ADV_MAX_IDX = 7'h0c;
  localparam logic [7:0] ADV_RSV_RST   = 8'h00;
  localparam logic [DATA_W-1:0] ADV_DATA_RST = 16'h0000;

  // indications register layout
  localparam int unsigned DLY_TX_BIT = 9;
  localparam int unsigned DLY_RX_BIT = 8;
  localparam int unsigned POL_BIT    = 4;
  localparam logic POL_RST           = 1'b0;

  // event flag and mask layout, bits FLAG_HI down to FLAG_LO
  localparam int unsigned FLAG_LO  = 1;
  localparam int unsigned FLAG_HI  = 10;
  localparam int unsigned FLAG_W   = FLAG_HI - FLAG_LO + 1;
  localparam int unsigned EV_OVF   = 10;
  localparam int unsigned EV_UNF   = 9;
  localparam int unsigned EV_IDLE  = 8;
  localparam int unsigned EV_NRG   = 7;
  localparam int unsigned EV_DONE  = 6;
  localparam int unsigned EV_RFLT  = 5;
  localparam int unsigned EV_LDN   = 4;
  localparam int unsigned EV_ACK   = 3;
  localparam int unsigned EV_DFLT  = 2;
  localparam int unsigned EV_PAGE  = 1;
  localparam logic [FLAG_W-1:0] FLAG_RST = 10'h000;
  localparam logic [FLAG_W-1:0] MASK_RST = 10'h000;

endpackage : pirq_pkg

// ===== hdl/pirq_flags.sv
// pirq_flags: latched-high event flags, cleared by writing ones.
// assumes set and clear are single-cycle, synchronous to the clock.
`timescale 1ns/1ps
module pirq_flags #(
  parameter int unsigned W = 10
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] flags_o
);

  typedef struct packed {
    logic [W-1:0] flags;
  } pirq_flags_st_t;

  pirq_flags_st_t st_r;
  pirq_flags_st_t st_nxt;
  logic [W-1:0]   flags_nxt;

  // a set in the clearing cycle wins
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign flags_nxt[i] = set_i[i] | (st_r.flags[i] & ~clr_i[i]);
    end
  endgenerate

  always_comb begin
    st_nxt       = st_r;
    st_nxt.flags = flags_nxt;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags_o = st_r.flags;

endmodule : pirq_flags

// ===== hdl/pirq_adv_port.sv
// pirq_adv_port: advanced register address port and read data port.
// assumes the advanced register contents answer adv_data_i in the
// same cycle that adv_rd_o and adv_sel_o are presented.
`timescale 1ns/1ps
module pirq_adv_port
  import pirq_pkg::*;
(
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wr_i,
  input  wire logic [DATA_W-1:0]    wdata_i,
  input  wire logic [DATA_W-1:0]    adv_data_i,
  output logic      [DATA_W-1:0]    port_o,
  output logic      [DATA_W-1:0]    data_o,
  output logic      [ADV_SEL_W-1:0] adv_sel_o,
  output logic                      adv_rd_o
);

  typedef struct packed {
    logic                 strobe;
    logic [7:0]           rsv;
    logic [ADV_IDX_W-1:0] idx;
    logic [DATA_W-1:0]    data;
  } pirq_adv_st_t;

  pirq_adv_st_t st_r;
  pirq_adv_st_t st_nxt;
  logic         go;

  assign go = wr_i & wdata_i[ADV_RD_BIT]
            & (wdata_i[ADV_IDX_W-1:0] <= ADV_MAX_IDX);

  always_comb begin
    st_nxt = st_r;
    if (st_r.strobe) begin
      st_nxt.data   = adv_data_i;
      st_nxt.strobe = 1'b0;
    end
    if (wr_i) begin
      st_nxt.rsv = wdata_i[ADV_RSV_HI:ADV_RSV_LO];
      st_nxt.idx = wdata_i[ADV_IDX_W-1:0];
    end
    if (go) begin
      st_nxt.strobe = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r.strobe <= 1'b0;
      st_r.rsv    <= ADV_RSV_RST;
      st_r.idx    <= '0;
      st_r.data   <= ADV_DATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign port_o    = {st_r.strobe, st_r.rsv, st_r.idx};
  assign data_o    = st_r.data;
  assign adv_sel_o = st_r.idx[ADV_SEL_W-1:0];
  assign adv_rd_o  = st_r.strobe;

endmodule : pirq_adv_port

// ===== verif/pirq_adv_model.sv
// pirq_adv_model: advanced register set behind the indirect read port.
// assumes the block presents select and read strobe in the same cycle.
`timescale 1ns/1ps
module pirq_adv_model (
  input  wire logic [3:0]  adv_sel_i,
  input  wire logic        adv_rd_i,
  output logic      [15:0] adv_data_o
);
  // outside a read the value is inverted, so a capture taken late shows up
  assign adv_data_o = adv_rd_i ? {12'ha50, adv_sel_i} : ~{12'ha50, adv_sel_i};
endmodule : pirq_adv_model

// ===== verif/pirq_regs_props.sv
// pirq_regs_props: port-level checks of the register block.
// assumes it is bound onto pirq_regs; all ports sampled on core_clk_i.
`timescale 1ns/1ps
module pirq_regs_props (
  input wire logic                           core_clk_i,
  input wire logic                           rst_i,
  input wire logic                           soft_rst_i,
  input wire logic                           reg_wr_i,
  input wire logic                           reg_rd_i,
  input wire logic [pirq_pkg::ADDR_W-1:0]    reg_addr_i,
  input wire logic [pirq_pkg::DATA_W-1:0]    reg_wdata_i,
  input wire logic [pirq_pkg::DATA_W-1:0]    reg_rdata_o,
  input wire logic                           reg_rvalid_o,
  input wire logic                           internal_delay_strap_i,
  input wire logic [pirq_pkg::ADV_SEL_W-1:0] adv_sel_o,
  input wire logic                           adv_rd_o,
  input wire logic                           tx_delay_en_o,
  input wire logic                           rx_delay_en_o,
  input wire logic                           irq_o
);
  import pirq_pkg::*;
  logic adv_go;
  logic ind_wr;
  assign adv_go = reg_wr_i && reg_addr_i == ADV_ADDR_OFS && reg_wdata_i[ADV_RD_BIT] && reg_wdata_i[6:0] <= ADV_MAX_IDX;
  assign ind_wr = reg_wr_i && reg_addr_i == IND_OFS;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i || soft_rst_i);
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
  a_answer_pulse: assert property (!reg_rd_i |=> !reg_rvalid_o) else $error("stray read valid");
  a_adv_start: assert property (adv_go |=> adv_rd_o && adv_sel_o == $past(reg_wdata_i[3:0]))
    else $error("advanced read not started");
  a_adv_quiet: assert property (!adv_go |=> !adv_rd_o) else $error("advanced read without request");
  a_delay_strap: assert property (disable iff (1'b0) rst_i |=> tx_delay_en_o == !$past(internal_delay_strap_i)
    && rx_delay_en_o == !$past(internal_delay_strap_i)) else $error("delay reset value wrong");
  a_delay_hold: assert property (!ind_wr |=> $stable(tx_delay_en_o) && $stable(rx_delay_en_o))
    else $error("delay bits changed without write");
  a_delay_write: assert property (ind_wr |=> tx_delay_en_o == $past(reg_wdata_i[9])
    && rx_delay_en_o == $past(reg_wdata_i[8])) else $error("delay bits not written");
  a_flag_reserved: assert property (reg_rd_i && reg_addr_i == FLAG_OFS |=> reg_rdata_o[15:11] == 5'h00
    && !reg_rdata_o[0]) else $error("flag reserved bits not zero");
  a_ind_reserved: assert property (reg_rd_i && reg_addr_i == IND_OFS |=> reg_rdata_o[15:10] == 6'h00
    && reg_rdata_o[7:5] == 3'h0 && reg_rdata_o[3:0] == 4'h0) else $error("indication reserved bits not zero");
  a_irq_masked: assert property (reg_wr_i && reg_addr_i == MASK_OFS && reg_wdata_i == 16'h0000 |=> ##1 !irq_o)
    else $error("irq not released after mask clear");
endmodule : pirq_regs_props
bind pirq_regs pirq_regs_props u_props (.*);

// ===== verif/tb_pirq_regs.sv
// tb_pirq_regs: self-checking bench for the register block.
// assumes pirq_pkg, pirq_regs and pirq_adv_model are compiled first.
`timescale 1ns/1ps
module tb_pirq_regs;
  import pirq_pkg::*;
  logic                 clk = 0, rst = 1, srst = 0, wr_en = 0, rd_en = 0, rvalid, strap = 0, pol = 0;
  logic                 nrg = 0, link = 0, txd, rxd, irq, adv_rd;
  logic [ADDR_W-1:0]    addr = '0;
  logic [DATA_W-1:0]    wdata = '0, rdata, adv_data;
  logic [11:1]          ev = '0;
  logic [ADV_SEL_W-1:0] adv_sel;
  int                   n_errors = 0, compares = 0, cyc = 0;
  always #4 clk = ~clk;
  pirq_regs u_dut (.core_clk_i(clk), .rst_i(rst), .soft_rst_i(srst), .reg_wr_i(wr_en), .reg_rd_i(rd_en),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .internal_delay_strap_i(strap), .ten_meg_polarity_reversed_i(pol), .energy_detected_status_i(nrg),
    .link_status_i(link), .tx_buffer_overflow_i(ev[10]), .tx_buffer_underflow_i(ev[9]),
    .idle_error_overflow_i(ev[8]), .negotiation_done_i(ev[6]), .remote_fault_i(ev[5]),
    .partner_ack_i(ev[3]), .parallel_detect_fault_i(ev[2]), .role_fault_i(ev[11]),
    .page_received_i(ev[1]), .adv_data_i(adv_data), .adv_sel_o(adv_sel), .adv_rd_o(adv_rd),
    .tx_delay_en_o(txd), .rx_delay_en_o(rxd), .irq_o(irq));
  pirq_adv_model u_adv (.adv_sel_i(adv_sel), .adv_rd_i(adv_rd), .adv_data_o(adv_data));
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(logic [4:0] a, logic [15:0] d);
    @(negedge clk);
    wr_en = 1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_en = 0;
  endtask : wr
  task automatic rd(logic [4:0] a, logic [15:0] exp);
    @(negedge clk);
    rd_en = 1;
    addr = a;
    @(negedge clk);
    rd_en = 0;
    chk("rvalid", {15'h0, rvalid}, 16'h1);
    chk("rdata", rdata, exp);
  endtask : rd
  task automatic do_reset(logic s);
    strap = s;
    rst = 1;
    repeat (12) @(negedge clk);
    rst = 0;
  endtask : do_reset
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic t_reset();
    chk("delay", {14'h0, txd, rxd}, 16'h3);
    rd(IND_OFS, 16'h0300);
    rd(FLAG_OFS, 16'h0);
    rd(MASK_OFS, 16'h0);
    rd(ADV_DATA_OFS, 16'h0);
    rd(5'h00, 16'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_ind();
    wr(IND_OFS, 16'hffff);
    rd(IND_OFS, 16'h0300);
    pol = 1;
    wr(IND_OFS, 16'h0200);
    rd(IND_OFS, 16'h0210);
    chk("delay", {14'h0, txd, rxd}, 16'h2);
    do_reset(1);
    rd(IND_OFS, 16'h0010);
    pol = 0;
    $display("test indications done");
  endtask : t_ind
  task automatic t_adv();
    for (int i = 0; i <= 13; i++) begin
      wr(ADV_ADDR_OFS, 16'h8000 | i[15:0]);
      rd(ADV_DATA_OFS, 16'ha500 | (i > 12 ? 16'h000c : i[15:0]));
    end
    rd(ADV_ADDR_OFS, 16'h000d);
    wr(ADV_DATA_OFS, 16'hffff);
    rd(ADV_DATA_OFS, 16'ha50c);
    wr(ADV_ADDR_OFS, 16'h0180);
    rd(ADV_ADDR_OFS, 16'h0180);
    $display("test advanced port done");
  endtask : t_adv
  task automatic t_events();
    wr(MASK_OFS, 16'hffff);
    rd(MASK_OFS, 16'h07fe);
    link = 1;
    for (int b = 1; b <= 11; b++) begin
      @(negedge clk);
      if (b == 7) nrg = 1;
      else if (b == 4) link = 0;
      else ev[b] = 1;
      @(negedge clk);
      ev = '0;
      link = 1;
      repeat (2) @(negedge clk);
      chk("irq", {15'h0, irq}, 16'h1);
      rd(FLAG_OFS, 16'h1 << (b == 11 ? 2 : b));
      wr(FLAG_OFS, 16'hffff);
      nrg = 0;
      repeat (2) @(negedge clk);
      chk("irq", {15'h0, irq}, 16'h0);
      rd(FLAG_OFS, 16'h0);
    end
    $display("test events done");
  endtask : t_events
  task automatic t_mask();
    wr(MASK_OFS, 16'h0);
    @(negedge clk);
    ev[5] = 1;
    @(negedge clk);
    ev = '0;
    repeat (2) @(negedge clk);
    chk("irq", {15'h0, irq}, 16'h0);
    rd(FLAG_OFS, 16'h0020);
    wr(MASK_OFS, 16'h0020);
    repeat (2) @(negedge clk);
    chk("irq", {15'h0, irq}, 16'h1);
    wr(IND_OFS, 16'h0100);
    @(negedge clk);
    srst = 1;
    @(negedge clk);
    srst = 0;
    rd(FLAG_OFS, 16'h0);
    rd(MASK_OFS, 16'h0);
    rd(IND_OFS, 16'h0100);
    chk("irq", {15'h0, irq}, 16'h0);
    $display("test mask and soft reset done");
  endtask : t_mask
  initial begin
    do_reset(0);
    t_reset();
    t_ind();
    t_adv();
    t_events();
    t_mask();
    finish_test();
  end
  // the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      finish_test();
    end
  end
endmodule : tb_pirq_regs
